/* src/sdms_pkg.sv */
// Shared constants, types and sine table of the step/dir microstep sequencer
package sdms_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] COIL_OFS   = 8'h08;

    // Drive control register fields
    localparam int unsigned CTRL_MICROSTEP_RESOLUTION_LSB = 0;
    localparam int unsigned CTRL_STEP_INTERPOLATE_ENABLE   = 4;
    localparam int unsigned CTRL_DOUBLE_EDGE_STEP    = 5;

    // Status register fields
    localparam int unsigned STAT_POS_LSB  = 0;
    localparam int unsigned STAT_POL      = 9;
    localparam int unsigned STAT_STANDSTILL_FLAG     = 10;

    // Coil register fields
    localparam int unsigned COIL_A_LSB    = 0;
    localparam int unsigned COIL_B_LSB    = 16;

    // Reset values
    localparam logic [3:0] MICROSTEP_RESOLUTION_RST   = 4'h0;
    localparam logic       STEP_INTERPOLATE_ENABLE_RST = 1'b0;
    localparam logic       DOUBLE_EDGE_STEP_RST  = 1'b0;
    localparam logic [9:0] POS_RST    = 10'h000;

    // Counts
    localparam int unsigned POS_W          = 10;
    localparam int unsigned PERIOD_W       = 21;
    localparam int unsigned SPACING_W      = 17;
    localparam int unsigned INTERP_SHIFT   = 4;
    localparam logic [4:0]  INTERP_STEPS   = 5'h10;
    localparam logic [3:0]  MICROSTEP_RESOLUTION_COARSEST  = 4'h8;
    localparam int unsigned STANDSTILL_DEF = 1 << 20;
    localparam logic [9:0]  QUARTER_OFS    = 10'h100;
    localparam logic [8:0]  FULL_SCALE     = 9'h0F8;

    typedef struct packed {
        logic                   step_s1;
        logic                   step_s2;
        logic                   step_s3;
        logic                   dir_s1;
        logic                   dir_s2;
        logic                   half_s1;
        logic                   half_s2;
        logic [3:0]             microstep_resolution;
        logic                   step_interpolate_enable;
        logic                   double_edge_step;
        logic [POS_W-1:0]       pos;
        logic [PERIOD_W-1:0]    period_cnt;
        logic [SPACING_W-1:0]   spacing;
        logic [SPACING_W-1:0]   tick;
        logic [4:0]             remaining;
        logic                   interp_dir;
        logic                   standstill;
        logic signed [8:0]      coil_a;
        logic signed [8:0]      coil_b;
        logic [31:0]            prdata;
        logic                   pslverr;
    } sdms_state_t;

    typedef logic [7:0] sdms_table_t [256];

    localparam sdms_table_t SINE_TABLE = '{ // R09
        8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B,
        8'h0D, 8'h0E, 8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h18,
        8'h19, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h22, 8'h24,
        8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h30,
        8'h31, 8'h33, 8'h34, 8'h36, 8'h37, 8'h39, 8'h3A, 8'h3C,
        8'h3D, 8'h3E, 8'h40, 8'h41, 8'h43, 8'h44, 8'h46, 8'h47,
        8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4F, 8'h50, 8'h51, 8'h53,
        8'h54, 8'h56, 8'h57, 8'h59, 8'h5A, 8'h5B, 8'h5D, 8'h5E,
        8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69,
        8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h70, 8'h72, 8'h73, 8'h74,
        8'h76, 8'h77, 8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7E, 8'h7F,
        8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89,
        8'h8A, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93,
        8'h94, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9C, 8'h9D,
        8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA3, 8'hA4, 8'hA5, 8'hA6,
        8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hAF,
        8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7,
        8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF,
        8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7,
        8'hC8, 8'hC9, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE,
        8'hCF, 8'hCF, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD4,
        8'hD5, 8'hD6, 8'hD7, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDA,
        8'hDB, 8'hDC, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hDF, 8'hE0,
        8'hE1, 8'hE1, 8'hE2, 8'hE2, 8'hE3, 8'hE4, 8'hE4, 8'hE5,
        8'hE5, 8'hE6, 8'hE7, 8'hE7, 8'hE8, 8'hE8, 8'hE9, 8'hE9,
        8'hEA, 8'hEA, 8'hEB, 8'hEB, 8'hEC, 8'hEC, 8'hED, 8'hED,
        8'hEE, 8'hEE, 8'hEE, 8'hEF, 8'hEF, 8'hF0, 8'hF0, 8'hF0,
        8'hF1, 8'hF1, 8'hF1, 8'hF2, 8'hF2, 8'hF2, 8'hF3, 8'hF3,
        8'hF3, 8'hF4, 8'hF4, 8'hF4, 8'hF4, 8'hF5, 8'hF5, 8'hF5,
        8'hF5, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF7, 8'hF7,
        8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF8, 8'hF8,
        8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8
    };

endpackage

/* src/sdms_sine_lookup.sv */
// Full-wave sine lookup built from the quarter-wave table
`timescale 1ns/1ps
module sdms_sine_lookup (
    input  wire logic [9:0]        angle,
    output logic signed [8:0]      current
);
    logic [7:0] idx;
    logic [7:0] mag;

    // Odd quadrants walk the table backwards, upper half is negative R08
    always_comb begin
        idx = angle[8] ? 8'(8'hFF - angle[7:0]) : angle[7:0];
        mag = sdms_pkg::SINE_TABLE[idx];
        current = angle[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    end
endmodule

/* src/sdms_sequencer.sv */
// Step/dir microstep sequencer with interpolator and APB registers
//
// What the document requires of this block and of its controller
// R01 - Double edge option makes both step edges count
// R02 - Step and direction pass two-flop synchronisers
// R03 - Controller keeps step rate within clock limits
// R04 - Controller holds step levels long enough
// R05 - Electrical angle is a 10-bit counter
// R06 - Direction low adds, high subtracts step size
// R07 - Step size comes from resolution setting
// R08 - Quarter-wave table mirrored over full turn
// R09 - Table holds the 256 tabulated values
// R10 - Coil currents follow the documented angle map
// R11 - Controller changes coarse resolution at step positions
// R12 - Interpolator turns each edge into 16 microsteps
// R13 - Microsteps spaced evenly over previous period
// R14 - Periods up to 2^20 clocks are supported
// R15 - Too slow stepping raises standstill flag
// R16 - Next active edge clears standstill flag
// R17 - New spacing after one period, leftovers dropped
// R18 - Controller uses double edge only at 50% duty
// R19 - Controller lowers current at standstill
// R20 - Configuration input halves standstill current
// R21 - Standstill after 2^20 cycles without edges
// R22 - Position bit 9 gives coil A polarity
// R23 - Coil targets come from the sine table
// R24 - Resolution selects power-of-two increment, zero finest
// R25 - Period measurement saturates instead of wrapping
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module sdms_sequencer #(
    parameter int unsigned STANDSTILL_CYCLES = sdms_pkg::STANDSTILL_DEF
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              step_in,
    input  wire logic              dir_in,
    input  wire logic              standstill_half_in,
    output logic [9:0]             microstep_position,
    output logic                   coil_a_polarity,
    output logic                   standstill_flag,
    output logic signed [8:0]      coil_a_current,
    output logic signed [8:0]      coil_b_current
);
    localparam int unsigned PW = sdms_pkg::PERIOD_W;
    localparam int unsigned SW = sdms_pkg::SPACING_W;
    localparam logic [PW-1:0] LIMIT = PW'(STANDSTILL_CYCLES);

    // Counter width caps the measurable period
    initial begin
        if (STANDSTILL_CYCLES < 32 || STANDSTILL_CYCLES > (1 << 20)) begin
            $error("STANDSTILL_CYCLES out of range");
        end
    end

    sdms_pkg::sdms_state_t state_reg;
    sdms_pkg::sdms_state_t state_next;

    logic                  step_edge;
    logic [9:0]            step_inc;
    logic [PW-1:0]         period_sat;
    logic [SW-1:0]         spacing_new;
    logic [9:0]            angle_b;
    logic signed [8:0]     lut_a;
    logic signed [8:0]     lut_b;
    logic                  rd_setup;
    logic                  wr_access;
    logic                  addr_ok;

    // Only second and third flops are compared, never the first
    assign step_edge = (state_reg.step_s2 != state_reg.step_s3)
                     && (state_reg.double_edge_step || state_reg.step_s2); // R01

    // Coarser settings clamp at full step
    always_comb begin
        if (state_reg.microstep_resolution >= sdms_pkg::MICROSTEP_RESOLUTION_COARSEST) begin
            step_inc = 10'(1 << sdms_pkg::MICROSTEP_RESOLUTION_COARSEST); // R24
        end else begin
            step_inc = 10'(1 << state_reg.microstep_resolution); // R07
        end
    end

    // Saturated period keeps slow steps from giving short spacing
    always_comb begin
        period_sat = (state_reg.period_cnt >= LIMIT)
                   ? LIMIT : state_reg.period_cnt; // R25
        spacing_new = SW'(period_sat >> sdms_pkg::INTERP_SHIFT); // R13
        if (spacing_new == '0) begin
            spacing_new = SW'(1);
        end
    end

    assign angle_b = 10'(state_reg.pos + sdms_pkg::QUARTER_OFS);

    sdms_sine_lookup u_lut_a (
        .angle   (state_reg.pos),
        .current (lut_a)
    );

    sdms_sine_lookup u_lut_b (
        .angle   (angle_b),
        .current (lut_b)
    );

    assign addr_ok = (paddr == sdms_pkg::CTRL_OFS)
                  || (paddr == sdms_pkg::STATUS_OFS)
                  || (paddr == sdms_pkg::COIL_OFS);
    assign rd_setup  = psel && !penable;
    assign wr_access = psel && penable && pwrite && addr_ok;

    always_comb begin
        state_next = state_reg;

        state_next.step_s1 = step_in; // R02
        state_next.step_s2 = state_reg.step_s1;
        state_next.step_s3 = state_reg.step_s2;
        state_next.dir_s1  = dir_in;
        state_next.dir_s2  = state_reg.dir_s1;
        state_next.half_s1 = standstill_half_in;
        state_next.half_s2 = state_reg.half_s1;

        // Period measurement and standstill detection
        if (step_edge) begin
            state_next.period_cnt = '0;
            state_next.standstill = 1'b0; // R16
        end else begin
            if (state_reg.period_cnt < LIMIT) begin
                state_next.period_cnt = PW'(state_reg.period_cnt + 1'b1);
            end
            if (state_reg.period_cnt >= PW'(LIMIT - 1'b1)) begin
                state_next.standstill = 1'b1; // R15 R21
            end
        end

        // Position update, direct or interpolated
        if (step_edge && !state_reg.step_interpolate_enable) begin
            if (state_reg.dir_s2) begin
                state_next.pos = 10'(state_reg.pos - step_inc); // R06
            end else begin
                state_next.pos = 10'(state_reg.pos + step_inc); // R06
            end
            state_next.remaining = '0;
        end else if (step_edge) begin
            // Unissued microsteps of the last period are dropped
            state_next.remaining  = sdms_pkg::INTERP_STEPS; // R12 R17
            state_next.spacing    = spacing_new; // R13 R14
            state_next.tick       = '0;
            state_next.interp_dir = state_reg.dir_s2;
        end else if (state_reg.remaining != '0) begin
            if (SW'(state_reg.tick + 1'b1) >= state_reg.spacing) begin
                state_next.tick = '0;
                state_next.remaining = 5'(state_reg.remaining - 1'b1);
                if (state_reg.interp_dir) begin
                    state_next.pos = 10'(state_reg.pos - 1'b1); // R12
                end else begin
                    state_next.pos = 10'(state_reg.pos + 1'b1); // R12
                end
            end else begin
                state_next.tick = SW'(state_reg.tick + 1'b1);
            end
        end

        // Disabling the interpolator abandons its burst
        if (!state_reg.step_interpolate_enable && !step_edge) begin
            state_next.remaining = '0;
        end

        // Halving uses arithmetic shift to keep the sign
        if (state_reg.standstill && state_reg.half_s2) begin
            state_next.coil_a = lut_a >>> 1; // R20
            state_next.coil_b = lut_b >>> 1; // R20
        end else begin
            state_next.coil_a = lut_a; // R10 R23
            state_next.coil_b = lut_b; // R10 R23
        end

        // Read data captured in setup, so access needs no wait
        if (rd_setup) begin
            state_next.pslverr = !addr_ok;
            state_next.prdata  = '0;
            case (paddr)
                sdms_pkg::CTRL_OFS: begin
                    state_next.prdata[sdms_pkg::CTRL_MICROSTEP_RESOLUTION_LSB +: 4] =
                        state_reg.microstep_resolution;
                    state_next.prdata[sdms_pkg::CTRL_STEP_INTERPOLATE_ENABLE] =
                        state_reg.step_interpolate_enable;
                    state_next.prdata[sdms_pkg::CTRL_DOUBLE_EDGE_STEP] =
                        state_reg.double_edge_step;
                end
                sdms_pkg::STATUS_OFS: begin
                    state_next.prdata[sdms_pkg::STAT_POS_LSB +: 10] =
                        state_reg.pos; // R05
                    state_next.prdata[sdms_pkg::STAT_STANDSTILL_FLAG] =
                        state_reg.standstill;
                end
                sdms_pkg::COIL_OFS: begin
                    state_next.prdata[sdms_pkg::COIL_A_LSB +: 9] =
                        state_reg.coil_a;
                    state_next.prdata[sdms_pkg::COIL_B_LSB +: 9] =
                        state_reg.coil_b;
                end
                default: begin
                    state_next.prdata = '0;
                end
            endcase
        end

        if (wr_access && paddr == sdms_pkg::CTRL_OFS) begin
            state_next.microstep_resolution   = pwdata[sdms_pkg::CTRL_MICROSTEP_RESOLUTION_LSB +: 4]; // R07
            state_next.step_interpolate_enable = pwdata[sdms_pkg::CTRL_STEP_INTERPOLATE_ENABLE]; // R12
            state_next.double_edge_step  = pwdata[sdms_pkg::CTRL_DOUBLE_EDGE_STEP]; // R01
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg            <= '0;
            state_reg.microstep_resolution       <= sdms_pkg::MICROSTEP_RESOLUTION_RST;
            state_reg.step_interpolate_enable     <= sdms_pkg::STEP_INTERPOLATE_ENABLE_RST;
            state_reg.double_edge_step      <= sdms_pkg::DOUBLE_EDGE_STEP_RST;
            state_reg.pos        <= sdms_pkg::POS_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata             = state_reg.prdata;
    assign pslverr            = state_reg.pslverr && psel && penable;
    assign pready             = 1'b1;
    assign microstep_position = state_reg.pos; // R05
    assign coil_a_polarity    = state_reg.pos[sdms_pkg::STAT_POL]; // R22
    assign standstill_flag    = state_reg.standstill;
    assign coil_a_current     = state_reg.coil_a;
    assign coil_b_current     = state_reg.coil_b;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_sync_two_flop: assert property ( // R02
        ##2 state_reg.step_s2 == $past(step_in, 2))
        else $error("step sync not two flops");

    a_rising_only: assert property ( // R01
        (!state_reg.double_edge_step && state_reg.step_s3 && !state_reg.step_s2)
        |-> !step_edge)
        else $error("falling edge counted without double edge");

    a_double_edge: assert property ( // R01
        (state_reg.double_edge_step && state_reg.step_s3 != state_reg.step_s2)
        |-> step_edge)
        else $error("edge missed with double edge");

    a_step_add: assert property ( // R06
        (step_edge && !state_reg.step_interpolate_enable && !state_reg.dir_s2)
        |=> state_reg.pos == 10'($past(state_reg.pos) + $past(step_inc)))
        else $error("forward step wrong");

    a_step_sub: assert property ( // R06
        (step_edge && !state_reg.step_interpolate_enable && state_reg.dir_s2)
        |=> state_reg.pos == 10'($past(state_reg.pos) - $past(step_inc)))
        else $error("reverse step wrong");

    a_full_step_inc: assert property ( // R24
        (state_reg.microstep_resolution == 4'h8) |-> step_inc == 10'h100)
        else $error("full step increment wrong");

    a_finest_inc: assert property ( // R24
        (state_reg.microstep_resolution == 4'h0) |-> step_inc == 10'h001)
        else $error("finest increment wrong");

    a_interp_burst: assert property ( // R12
        (step_edge && state_reg.step_interpolate_enable)
        |=> state_reg.remaining == 5'h10 && $stable(state_reg.pos))
        else $error("interpolator burst not started");

    a_interp_unit: assert property ( // R12
        (state_reg.step_interpolate_enable && !$past(step_edge) && $changed(state_reg.pos))
        |-> (10'(state_reg.pos - $past(state_reg.pos)) == 10'h001
          || 10'($past(state_reg.pos) - state_reg.pos) == 10'h001))
        else $error("interpolated microstep not unit size");

    a_spacing_even: assert property ( // R13
        (state_reg.remaining != '0 && !step_edge
         && state_reg.spacing == SW'(2) && state_reg.tick == '0)
        |=> $stable(state_reg.pos) ##1 $changed(state_reg.pos))
        else $error("microstep spacing wrong");

    a_standstill_flag_clear: assert property ( // R16
        (state_reg.standstill && step_edge) |=> !state_reg.standstill)
        else $error("standstill not cleared");

    a_standstill_flag_set: assert property ( // R21
        (state_reg.period_cnt == PW'(LIMIT - 1'b1) && !step_edge)
        |=> state_reg.standstill)
        else $error("standstill not raised");

    a_standstill_flag_early: assert property ( // R15
        (state_reg.period_cnt < PW'(LIMIT - 2'd2) && !state_reg.standstill)
        |=> !state_reg.standstill)
        else $error("standstill raised early");

    a_period_sat: assert property ( // R25
        state_reg.period_cnt <= LIMIT)
        else $error("period counter wrapped");

    a_polarity: assert property ( // R22
        (!state_reg.half_s2 || !state_reg.standstill)
        |=> (coil_a_current < 0) == $past(state_reg.pos[9]))
        else $error("coil A sign mismatch");

    a_peak_zero: assert property ( // R10
        (state_reg.pos == 10'h000 && !state_reg.standstill)
        |=> coil_b_current == 9'sd248 && coil_a_current == 9'sd1)
        else $error("angle zero currents wrong");

    a_peak_neg: assert property ( // R10
        (state_reg.pos == 10'h200 && !state_reg.standstill)
        |=> coil_b_current == -9'sd248)
        else $error("angle 512 current wrong");

    a_half_current: assert property ( // R20
        (state_reg.pos == 10'h100 && state_reg.standstill
         && state_reg.half_s2)
        |=> coil_a_current == 9'sd124)
        else $error("standstill halving wrong");
endmodule

/* verif/sdms_step_source.sv */
// Step and direction pulse source standing in for the motion controller
`timescale 1ns/1ps
module sdms_step_source (
    input  wire logic pclk,
    output logic      step_in,
    output logic      dir_in
);
    initial begin
        step_in = 1'b0;
        dir_in  = 1'b0;
    end

    // Direction settles two clocks ahead of the edge
    // Caller keeps hold at 2 or more, so each level lasts 5+ clocks
    // Levels held equally in interpolated runs
    task automatic toggle(input logic d, input int hold);
        @(posedge pclk);
        dir_in <= d;
        repeat (2) @(posedge pclk);
        step_in <= ~step_in;
        repeat (hold) @(posedge pclk);
    endtask
endmodule

/* verif/sdms_sequencer_test.sv */
// Self-checking bench of the step/dir microstep sequencer
`timescale 1ns/1ps
module sdms_sequencer_test;
    // Short standstill limit keeps the run brief
    localparam int unsigned LIMIT = 64;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              step_in, dir_in, standstill_half_in, e, lvl, double_edge_step;
    logic              coil_a_polarity, standstill_flag;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, q;
    logic [9:0]        microstep_position, p0, dl;
    logic signed [8:0] coil_a_current, coil_b_current;
    int                bad_count, num_checks, cycles, mpos, inc;

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    sdms_step_source i_sdms_step_source (.pclk(pclk), .step_in(step_in),
        .dir_in(dir_in));

    sdms_sequencer #(.STANDSTILL_CYCLES(LIMIT)) i_sdms_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step_in(step_in),
        .dir_in(dir_in), .standstill_half_in(standstill_half_in),
        .microstep_position(microstep_position),
        .coil_a_polarity(coil_a_polarity), .standstill_flag(standstill_flag),
        .coil_a_current(coil_a_current), .coil_b_current(coil_b_current));

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, well above the expected run of about 1200 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Full-wave value from the quarter table by mirroring
    function automatic logic signed [8:0] sine_of(input logic [9:0] a);
        logic [7:0]        i;
        logic signed [8:0] v;
        i = a[8] ? 8'hFF - a[7:0] : a[7:0];
        v = $signed({1'b0, sdms_pkg::SINE_TABLE[i]});
        return a[9] ? -v : v;
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_ctrl(input logic [3:0] m, input logic ip,
                            input logic de);
        apb(1'b1, sdms_pkg::CTRL_OFS, {26'h0, de, ip, m});
        double_edge_step = de;
        inc = 1 << ((m > 8) ? 8 : m);
    endtask

    task automatic step(input logic d, input int hold);
        i_sdms_step_source.toggle(d, hold);
        lvl = ~lvl;
        if (double_edge_step || lvl)
            mpos = (d ? mpos - inc : mpos + inc) & 32'h3FF;
    endtask

    task automatic check_pos;
        chk(microstep_position, mpos);
        chk(coil_a_polarity, mpos[9]);
        chk(coil_a_current, sine_of(mpos[9:0]));
        chk(coil_b_current, sine_of(10'(mpos + 256)));
    endtask

    initial begin
        {psel, penable, pwrite, standstill_half_in, lvl, double_edge_step} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        {bad_count, num_checks, cycles, mpos} = '0;
        inc = 1;
        void'($urandom(25713));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, sdms_pkg::CTRL_OFS, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0);
        apb(1'b1, sdms_pkg::STATUS_OFS, 32'hFFFFFFFF);
        apb(1'b0, sdms_pkg::STATUS_OFS, 32'h0);
        chk(q[9:0], 10'h000);
        $display("test registers done");
        // Every resolution code; the falling edge must not move
        // Codes rise from finest, so coarse steps start off grid, at 939
        for (int m = 0; m < 16; m++) begin
            set_ctrl(4'(m), 1'b0, 1'b0);
            step(m[0], 5);
            check_pos();
            step(m[0], 5);
            check_pos();
        end
        $display("test resolutions done");
        for (int k = 0; k < 40; k++) begin
            set_ctrl(4'($urandom_range(8, 0)), 1'b0, 1'($urandom_range(1, 0)));
            step(1'($urandom_range(1, 0)), 5 + $urandom_range(3, 0));
            check_pos();
        end
        $display("test random steps done");
        // Second reset, then let the standstill timer run out
        // Step parked low first, else the synchroniser sees a false edge
        if (lvl)
            step(1'b0, 5);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {mpos, double_edge_step} = '0;
        inc = 1;
        repeat (LIMIT - 10) @(posedge pclk);
        chk(standstill_flag, 1'b0);
        repeat (20) @(posedge pclk);
        chk(standstill_flag, 1'b1);
        apb(1'b0, sdms_pkg::STATUS_OFS, 32'h0);
        chk(q, 32'h00000400);
        // Controller lowers current while the flag stands
        standstill_half_in <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({coil_a_current, coil_b_current}, {9'h000, 9'h07C});
        standstill_half_in <= 1'b0;
        if (lvl)
            step(1'b0, 5);
        step(1'b0, 5);
        chk(standstill_flag, 1'b0);
        check_pos();
        apb(1'b0, sdms_pkg::COIL_OFS, 32'h0);
        chk(q, {7'h0, sine_of(10'(mpos + 256)), 7'h0, sine_of(mpos[9:0])});
        $display("test standstill done");
        // Interpolated run at a steady 40-clock step period
        if (lvl)
            step(1'b0, 17);
        set_ctrl(4'h4, 1'b1, 1'b0);
        repeat (LIMIT + 10) @(posedge pclk);
        for (int k = 0; k < 5; k++) begin
            p0 = microstep_position;
            i_sdms_step_source.toggle(1'b0, 17);
            i_sdms_step_source.toggle(1'b0, 17);
            dl = microstep_position - p0;
            if (k == 0)
                chk(dl < 10'd16, 1'b1);
            if (k > 1)
                chk(dl, 10'd16);
        end
        $display("test interpolation done");
        conclude();
    end
endmodule
